// [bci_arg_check.v]
// Argument check and setting index for one parsed command
`timescale 1ns/1ps
`include "bci_consts.vh"
module bci_arg_check (
  input  wire [7:0] letter,
  input  wire [6:0] value,
  input  wire [1:0] ndig,
  output reg        ok,
  output reg  [3:0] idx
);
  wire bin_ok = (ndig == 2'h1) && (value <= 7'h01);
  always @*
  begin
    ok  = 1'b0;
    idx = `BCI_IDX_NONE;
    case (letter)
      `BCI_LET_BRIDGE: begin idx = `BCI_IDX_BRIDGE; ok = bin_ok; end
      `BCI_LET_TXF:    begin idx = `BCI_IDX_TXF;    ok = bin_ok; end
      `BCI_LET_DLF:    begin idx = `BCI_IDX_DLF;    ok = bin_ok; end
      `BCI_LET_REM:    begin idx = `BCI_IDX_REM;    ok = bin_ok; end
      `BCI_LET_MAINT:  begin idx = `BCI_IDX_MAINT;  ok = bin_ok; end
      `BCI_LET_LOOP:   begin idx = `BCI_IDX_LOOP;   ok = bin_ok; end
      `BCI_LET_RESP:   begin idx = `BCI_IDX_RESP;   ok = bin_ok; end
      `BCI_LET_AGE:
      begin
        idx = `BCI_IDX_AGE;
        ok  = (ndig != 2'h0) && (value <= `BCI_AGE_MAX);
      end
      `BCI_LET_PRO:
      begin
        idx = `BCI_IDX_PRO;
        ok  = (ndig != 2'h0) && (value <= `BCI_PRO_MAX);
      end
      `BCI_LET_LOAD:   begin idx = `BCI_IDX_LOAD;   ok = (ndig == 2'h0); end
      `BCI_LET_TEST:   begin idx = `BCI_IDX_TEST;   ok = (ndig == 2'h0); end
      default:         begin idx = `BCI_IDX_NONE;   ok = 1'b0; end
    endcase
  end
endmodule // bci_arg_check

// [bci_asserts.sv]
// Checker for the configuration command interpreter ports
`timescale 1ns/1ps
// ============================================================
// Port relations
module bci_asserts (
  input wire       CLK,
  input wire       RESET,
  input wire       RX_VALID,
  input wire [7:0] RX_DATA,
  input wire       RX_LAST,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire [7:0] RDATA,
  input wire       RADIO_EN,
  input wire       TX_FILTER,
  input wire       DL_FILTER,
  input wire [5:0] AGING_MIN,
  input wire       REMOTE_ACCEPT,
  input wire       TABLE_MAINT,
  input wire       LOOP_SENSE,
  input wire [5:0] PRO_ADDR,
  input wire       RESP_8023,
  input wire       ACK_ONCE,
  input wire       TEST_TX,
  input wire       OWN_ADDR_INSERT,
  input wire       NV_WE,
  input wire [3:0] NV_ADDR,
  input wire [7:0] NV_DATA,
  input wire       TABLE_LOADING,
  input wire       TBL_VALID,
  input wire [7:0] TBL_DATA,
  input wire       TBL_LAST
);
  wire [7:0] settings = {ACK_ONCE, RESP_8023, LOOP_SENSE, TABLE_MAINT,
                         REMOTE_ACCEPT, DL_FILTER, TX_FILTER, RADIO_EN};
  wire       end_load = WR && ADDR == 8'h0C && WDATA[0];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  rdata_idle_a:
    assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside a read");
  settings_read_a:
    assert property ($past(RD) && $past(ADDR) == 8'h00 |->
                     RDATA == $past(settings))
    else $error("settings read does not match outputs");
  ack_once_a:
    assert property (ACK_ONCE == 1'b1)
    else $error("acknowledge count not one");
  own_insert_a:
    assert property (OWN_ADDR_INSERT == ($past(RESET, 2) && !$past(RESET)))
    else $error("own address insert pulse misplaced");
  test_radio_a:
    assert property (!RADIO_EN |=> !TEST_TX)
    else $error("test transmission with radio off");
  nv_pulse_a:
    assert property (NV_WE |-> $past(RX_VALID) && !$past(NV_WE)
                     && NV_ADDR != 4'h5)
    else $error("storage write out of place");
  nv_apply_a:
    assert property (NV_WE && NV_ADDR == 4'h3 |-> {2'b00, AGING_MIN} == NV_DATA)
    else $error("aging not applied with its storage write");
  tbl_fwd_a:
    assert property (TBL_VALID |-> $past(RX_VALID) && TBL_DATA == $past(RX_DATA)
                     && TBL_LAST == $past(RX_LAST))
    else $error("table byte not forwarded one cycle later");
  load_hold_a:
    assert property (TABLE_LOADING && !end_load |=> TABLE_LOADING)
    else $error("table loading ended without control write");
  no_parse_a:
    assert property (TABLE_LOADING && $past(TABLE_LOADING) |-> !NV_WE)
    else $error("command parsed during table loading");
  range_limit_a:
    assert property (AGING_MIN <= 6'h3C && PRO_ADDR <= 6'h20)
    else $error("setting beyond its limit");
  cover property (NV_WE && NV_ADDR == 4'h3);
  cover property (TBL_LAST);
  cover property ($rose(TEST_TX));
endmodule // bci_asserts
bind bci_cmd_interp bci_asserts bci_asserts_inst (.*);

// [bci_cmd_interp.v]
// Configuration command interpreter for the wireless bridge radio
// ============================================================
// Summary of operation
// - Bridge enable command 1 turns bridge on, 0 off; off stops radio.
// - Persistent settings are written to storage and applied immediately.
// - Transmit filter command 1 enables, 0 disables; enabled by default.
// - Download filter command 1 enables, 0 disables; enabled by default.
// - Aging takes 0 to 60 minutes; 0 disables; default five.
// - Remote accept command 1 permits remote commands, 0 refuses; refuse.
// - Table maintenance 1 on, 0 off; default on; filters stay usable.
// - Maintenance setting is volatile; host reissues it after power cycle.
// - Loop sense 1 on, 0 off; default on; kept in storage.
// - Table load readies the device; host sends table in next frames.
// - Uploaded table keeps being maintained unless maintenance is off.
// - Remote commands need own address in table; host includes it.
// - At power-up own station address is inserted into the table.
// - Professional address takes 0 to 32; 00 turns mode off; default off.
// - Response format 1 selects 802.3, 0 selects 802.2; 802.3 default.
// - Default: one acknowledgement per packet, loop on, static upload off.
// - Test command starts continuous pseudo-random spread transmission.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "bci_consts.vh"
module bci_cmd_interp (
  input  wire       CLK,
  input  wire       RESET,
  // Wired-side configuration frame bytes
  input  wire       RX_VALID,
  input  wire [7:0] RX_DATA,
  input  wire       RX_LAST,
  input  wire       RX_REMOTE,
  input  wire       OWN_ADDR_IN_TABLE,
  // Settings restored from non-volatile storage
  input  wire       NV_RD_VALID,
  input  wire [3:0] NV_RD_ADDR,
  input  wire [7:0] NV_RD_DATA,
  // Register port
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // Settings
  output reg        RADIO_EN,
  output reg        TX_FILTER,
  output reg        DL_FILTER,
  output reg  [5:0] AGING_MIN,
  output reg        REMOTE_ACCEPT,
  output reg        TABLE_MAINT,
  output reg        LOOP_SENSE,
  output reg  [5:0] PRO_ADDR,
  output reg        RESP_8023,
  output reg        ACK_ONCE,
  output reg        TEST_TX,
  output reg        OWN_ADDR_INSERT,
  // Non-volatile storage write
  output reg        NV_WE,
  output reg  [3:0] NV_ADDR,
  output reg  [7:0] NV_DATA,
  // Address table upload stream
  output reg        TABLE_LOADING,
  output reg        TBL_VALID,
  output reg  [7:0] TBL_DATA,
  output reg        TBL_LAST
);
  // ============================================================
  // Parser states
  localparam ST_PREFIX = 2'h0;
  localparam ST_LETTER = 2'h1;
  localparam ST_ARG    = 2'h2;
  localparam ST_SKIP   = 2'h3;

  reg  [1:0] state;
  reg  [2:0] pos;
  reg  [7:0] letter;
  reg  [6:0] value;
  reg  [1:0] ndig;
  reg        in_frame;
  reg        tbl_frame;
  reg        frame_ok;
  reg        powered;
  reg        last_err;
  wire       arg_ok;
  wire [3:0] arg_idx;

  // ============================================================
  // Prefix lookup
  function [7:0] pfx_char;
    input [2:0] p;
    begin
      case (p)
        3'h0:    pfx_char = `BCI_PFX0;
        3'h1:    pfx_char = `BCI_PFX1;
        3'h2:    pfx_char = `BCI_PFX2;
        3'h3:    pfx_char = `BCI_PFX3;
        3'h4:    pfx_char = `BCI_PFX4;
        3'h5:    pfx_char = `BCI_PFX5;
        default: pfx_char = `BCI_PFX6;
      endcase
    end
  endfunction

  // A bare letter on the final byte is a command with no digits
  wire [7:0] chk_letter = (state == ST_LETTER) ? RX_DATA : letter;

  bci_arg_check bci_arg_check_inst (
    .letter (chk_letter),
    .value  (value),
    .ndig   (ndig),
    .ok     (arg_ok),
    .idx    (arg_idx)
  );

  // ============================================================
  // Byte classification
  wire first_byte = RX_VALID && !in_frame;
  // Remote frames are taken only when allowed and own address is known
  wire accept_now = !RX_REMOTE || (REMOTE_ACCEPT && OWN_ADDR_IN_TABLE);
  wire frame_acc  = first_byte ? accept_now : frame_ok;
  wire to_table   = first_byte ? TABLE_LOADING : tbl_frame;
  wire is_digit   = (RX_DATA >= `BCI_CH_ZERO) && (RX_DATA <= `BCI_CH_NINE);
  wire [3:0] digit = RX_DATA[3:0];
  wire [6:0] next_value = (value << 3) + (value << 1) + {3'h0, digit};
  // A command ends at a space or at the end of its frame
  wire cmd_end = RX_VALID && !to_table && frame_acc &&
                 (((state == ST_ARG) && ((RX_DATA == `BCI_CH_SPACE) ||
                   (RX_LAST && !is_digit))) ||
                  ((state == ST_LETTER) && RX_LAST));
  wire last_digit = RX_VALID && !to_table && frame_acc &&
                    (state == ST_ARG) && RX_LAST && is_digit &&
                    (ndig != 2'h2);
  wire [6:0] exec_value = last_digit ? next_value : value;
  wire [1:0] exec_ndig  = last_digit ? ndig + 2'h1 : ndig;
  wire       execute    = cmd_end || last_digit;

  // Last digit on the final byte must reach the checker in the same cycle
  reg        exec_ok;
  reg  [3:0] exec_idx;
  always @*
  begin
    exec_idx = arg_idx;
    exec_ok  = arg_ok;
    if (last_digit)
    begin
      case (arg_idx)
        `BCI_IDX_AGE: exec_ok = exec_value <= `BCI_AGE_MAX;
        `BCI_IDX_PRO: exec_ok = exec_value <= `BCI_PRO_MAX;
        `BCI_IDX_LOAD, `BCI_IDX_TEST, `BCI_IDX_NONE: exec_ok = 1'b0;
        default: exec_ok = (exec_ndig == 2'h1) && (exec_value <= 7'h01);
      endcase
    end
  end

  // ============================================================
  // Frame parser
  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      state     <= ST_PREFIX;
      pos       <= 3'h0;
      letter    <= 8'h00;
      value     <= 7'h00;
      ndig      <= 2'h0;
      in_frame  <= 1'b0;
      tbl_frame <= 1'b0;
      frame_ok  <= 1'b0;
    end
    else if (RX_VALID)
    begin
      in_frame  <= !RX_LAST;
      tbl_frame <= to_table && !RX_LAST;
      frame_ok  <= frame_acc;
      if (RX_LAST || to_table || !frame_acc)
      begin
        state <= ST_PREFIX;
        pos   <= 3'h0;
        value <= 7'h00;
        ndig  <= 2'h0;
      end
      else
      begin
        case (state)
          ST_PREFIX:
          begin
            if (RX_DATA != pfx_char(pos))
              state <= ST_SKIP;
            else if (pos == `BCI_PREFIX_LEN - 3'h1)
              state <= ST_LETTER;
            else
              pos <= pos + 3'h1;
          end
          ST_LETTER:
          begin
            letter <= RX_DATA;
            value  <= 7'h00;
            ndig   <= 2'h0;
            state  <= ST_ARG;
          end
          ST_ARG:
          begin
            if (is_digit && ndig != 2'h2)
            begin
              value <= next_value;
              ndig  <= ndig + 2'h1;
            end
            else
              state <= ST_SKIP;
          end
          ST_SKIP: state <= ST_SKIP;
          default: state <= ST_SKIP;
        endcase
      end
    end
  end

  // ============================================================
  // Settings, storage writes and restore
  // Stored settings change only on a valid command, a restore or defaults
  wire wr_ctrl = WR && (ADDR == `BCI_REG_CTRL);
  wire do_defaults = wr_ctrl && WDATA[`BCI_CTRL_DEFAULTS];

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      RADIO_EN      <= `BCI_DEF_BRIDGE;
      TX_FILTER     <= `BCI_DEF_TXF;
      DL_FILTER     <= `BCI_DEF_DLF;
      AGING_MIN     <= `BCI_DEF_AGE;
      REMOTE_ACCEPT <= `BCI_DEF_REM;
      TABLE_MAINT   <= `BCI_DEF_MAINT;
      LOOP_SENSE    <= `BCI_DEF_LOOP;
      PRO_ADDR      <= `BCI_DEF_PRO;
      RESP_8023     <= `BCI_DEF_RESP;
      ACK_ONCE      <= 1'b1;
      NV_WE         <= 1'b0;
      NV_ADDR       <= 4'h0;
      NV_DATA       <= 8'h00;
      last_err      <= 1'b0;
    end
    else
    begin
      NV_WE <= 1'b0;
      if (do_defaults)
      begin
        RADIO_EN      <= `BCI_DEF_BRIDGE;
        TX_FILTER     <= `BCI_DEF_TXF;
        DL_FILTER     <= `BCI_DEF_DLF;
        AGING_MIN     <= `BCI_DEF_AGE;
        REMOTE_ACCEPT <= `BCI_DEF_REM;
        TABLE_MAINT   <= `BCI_DEF_MAINT;
        LOOP_SENSE    <= `BCI_DEF_LOOP;
        PRO_ADDR      <= `BCI_DEF_PRO;
        RESP_8023     <= `BCI_DEF_RESP;
      end
      else if (execute && exec_ok)
      begin
        last_err <= 1'b0;
        // Value takes effect now; storage is written in parallel
        case (exec_idx)
          `BCI_IDX_BRIDGE: RADIO_EN      <= exec_value[0];
          `BCI_IDX_TXF:    TX_FILTER     <= exec_value[0];
          `BCI_IDX_DLF:    DL_FILTER     <= exec_value[0];
          `BCI_IDX_AGE:    AGING_MIN     <= exec_value[5:0];
          `BCI_IDX_REM:    REMOTE_ACCEPT <= exec_value[0];
          `BCI_IDX_MAINT:  TABLE_MAINT   <= exec_value[0];
          `BCI_IDX_LOOP:   LOOP_SENSE    <= exec_value[0];
          `BCI_IDX_PRO:    PRO_ADDR      <= exec_value[5:0];
          `BCI_IDX_RESP:   RESP_8023     <= exec_value[0];
          default:         RESP_8023     <= RESP_8023;
        endcase
        // Maintenance stays volatile, so it never reaches storage
        if (exec_idx != `BCI_IDX_MAINT && exec_idx != `BCI_IDX_LOAD &&
            exec_idx != `BCI_IDX_TEST)
        begin
          NV_WE   <= 1'b1;
          NV_ADDR <= exec_idx;
          NV_DATA <= {1'b0, exec_value};
        end
      end
      else if (execute)
        last_err <= 1'b1;
      else if (NV_RD_VALID)
      begin
        case (NV_RD_ADDR)
          `BCI_IDX_BRIDGE: RADIO_EN      <= NV_RD_DATA[0];
          `BCI_IDX_TXF:    TX_FILTER     <= NV_RD_DATA[0];
          `BCI_IDX_DLF:    DL_FILTER     <= NV_RD_DATA[0];
          `BCI_IDX_AGE:    AGING_MIN     <= NV_RD_DATA[5:0];
          `BCI_IDX_REM:    REMOTE_ACCEPT <= NV_RD_DATA[0];
          `BCI_IDX_LOOP:   LOOP_SENSE    <= NV_RD_DATA[0];
          `BCI_IDX_PRO:    PRO_ADDR      <= NV_RD_DATA[5:0];
          `BCI_IDX_RESP:   RESP_8023     <= NV_RD_DATA[0];
          default:         RESP_8023     <= RESP_8023;
        endcase
      end
    end
  end

  // ============================================================
  // Table upload, test transmission and power-up insertion
  wire exec_load = execute && exec_ok && (exec_idx == `BCI_IDX_LOAD);
  wire exec_test = execute && exec_ok && (exec_idx == `BCI_IDX_TEST);

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      TABLE_LOADING   <= 1'b0;
      TBL_VALID       <= 1'b0;
      TBL_DATA        <= 8'h00;
      TBL_LAST        <= 1'b0;
      TEST_TX         <= 1'b0;
      OWN_ADDR_INSERT <= 1'b0;
      powered         <= 1'b0;
    end
    else
    begin
      powered         <= 1'b1;
      OWN_ADDR_INSERT <= !powered;
      // Loading set wins over a software end in the same cycle
      if (exec_load)
        TABLE_LOADING <= 1'b1;
      else if (wr_ctrl && WDATA[`BCI_CTRL_END_LOAD])
        TABLE_LOADING <= 1'b0;
      TBL_VALID <= RX_VALID && to_table;
      TBL_DATA  <= RX_VALID ? RX_DATA : TBL_DATA;
      TBL_LAST  <= RX_VALID && to_table && RX_LAST;
      // Test transmission needs the radio enabled
      if (exec_test && RADIO_EN)
        TEST_TX <= 1'b1;
      else if (!RADIO_EN || (wr_ctrl && WDATA[`BCI_CTRL_STOP_TEST]))
        TEST_TX <= 1'b0;
    end
  end

  // ============================================================
  // Register read port
  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      RDATA <= 8'h00;
    else if (RD)
    begin
      case (ADDR)
        `BCI_REG_SETTINGS: RDATA <= {ACK_ONCE, RESP_8023, LOOP_SENSE,
                                     TABLE_MAINT, REMOTE_ACCEPT, DL_FILTER,
                                     TX_FILTER, RADIO_EN};
        `BCI_REG_VALUES:   RDATA <= {2'h0, AGING_MIN};
        `BCI_REG_STATUS:   RDATA <= {2'h0, PRO_ADDR[5:0] == 6'h00,
                                     in_frame, OWN_ADDR_IN_TABLE,
                                     last_err, TEST_TX, TABLE_LOADING};
        default:           RDATA <= 8'h00;
      endcase
    end
    else
      RDATA <= 8'h00;
  end
endmodule // bci_cmd_interp

// [bci_cmd_interp_bench.sv]
// Self-checking bench for the configuration command interpreter
`timescale 1ns/1ps
`include "bci_consts.vh"
// ============================================================
// Bench top
module bci_cmd_interp_bench;
  logic       CLK, RESET, OWN_ADDR_IN_TABLE, NV_RD_VALID, WR, RD;
  logic [3:0] NV_RD_ADDR;
  logic [7:0] NV_RD_DATA, ADDR, WDATA, nv_d, s_exp;
  logic [3:0] nv_a;
  logic [7:0] tq [$];
  wire        RX_VALID, RX_LAST, RX_REMOTE, RADIO_EN, TX_FILTER, DL_FILTER;
  wire        REMOTE_ACCEPT, TABLE_MAINT, LOOP_SENSE, RESP_8023, ACK_ONCE;
  wire        TEST_TX, OWN_ADDR_INSERT, NV_WE, TABLE_LOADING, TBL_VALID;
  wire        TBL_LAST;
  wire  [7:0] RX_DATA, RDATA, NV_DATA, TBL_DATA;
  wire  [5:0] AGING_MIN, PRO_ADDR;
  wire  [3:0] NV_ADDR;
  int         n_mismatch, n_compared, nv_n, k, i, v, n_ins, n_tl;
  logic [7:0] lets [6] = '{`BCI_LET_BRIDGE, `BCI_LET_TXF, `BCI_LET_DLF,
                           `BCI_LET_REM, `BCI_LET_LOOP, `BCI_LET_RESP};
  int         idx [6] = '{0, 1, 2, 4, 6, 8};
  int         pos [6] = '{0, 1, 2, 3, 5, 6};

  bci_cmd_interp bci_cmd_interp_inst (.*);
  bci_station    bci_station_inst (.*);

  initial
  begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  always @(posedge CLK)
  begin
    if (NV_WE === 1'b1)
    begin
      nv_n <= nv_n + 1;
      nv_a <= NV_ADDR;
      nv_d <= NV_DATA;
    end
    if (TBL_VALID === 1'b1)
      tq.push_back(TBL_DATA);
    if (OWN_ADDR_INSERT === 1'b1)
      n_ins <= n_ins + 1;
    if (TBL_LAST === 1'b1)
      n_tl <= n_tl + 1;
  end

  // ============================================================
  // Tasks
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(n, e, RDATA);
  endtask
  task automatic cmd(input logic [7:0] l, input string a, input logic rem,
                     input int gap);
    logic [7:0] q [$];
    int j;
    q = '{`BCI_PFX0, `BCI_PFX1, `BCI_PFX2, `BCI_PFX3, `BCI_PFX4, `BCI_PFX5,
          `BCI_PFX6, l};
    for (j = 0; j < a.len(); j++)
      q.push_back(a[j]);
    bci_station_inst.send(q, rem, gap);
    repeat (2) @(posedge CLK);
    #1;
  endtask
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    RESET = 1'b1;
    OWN_ADDR_IN_TABLE = 1'b1;
    NV_RD_VALID = 1'b0;
    NV_RD_ADDR = 4'h0;
    NV_RD_DATA = 8'h00;
    ADDR = 8'h00;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    s_exp = 8'hF7;
    rd(8'h00, s_exp, "settings");
    rd(8'h04, 8'h05, "aging");
    rd(8'h08, 8'h28, "status");
    wr(8'h00, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00, "unmapped");
    rd(8'h0C, 8'h00, "control");
    for (i = 0; i < 6; i++)
      for (v = 0; v < 2; v++)
      begin
        k = nv_n;
        cmd(lets[i], v ? "1" : "0", 1'b0, i);
        s_exp[pos[i]] = v[0];
        rd(8'h00, s_exp, "settings");
        chk("nv count", k + 1, nv_n);
        chk("nv index", idx[i], nv_a);
        chk("nv value", v, nv_d);
      end
    cmd(`BCI_LET_AGE, "60", 1'b0, 0);
    cmd(`BCI_LET_AGE, "61", 1'b0, 0);
    rd(8'h04, 8'h3C, "aging");
    rd(8'h08, 8'h2C, "status");
    cmd(`BCI_LET_AGE, "0", 1'b0, 0);
    chk("aging", 8'h00, AGING_MIN);
    cmd(`BCI_LET_PRO, "32", 1'b0, 0);
    cmd(`BCI_LET_PRO, "33", 1'b0, 1);
    cmd(`BCI_LET_PRO, "100", 1'b0, 0);
    chk("pro", 8'h20, PRO_ADDR);
    cmd(`BCI_LET_PRO, "00", 1'b0, 0);
    chk("pro", 8'h00, PRO_ADDR);
    k = nv_n;
    cmd(8'h7A, "1", 1'b0, 0);
    chk("nv count", k, nv_n);
    rd(8'h00, s_exp, "settings");
    cmd(`BCI_LET_REM, "0", 1'b0, 0);
    cmd(`BCI_LET_TXF, "0", 1'b1, 0);
    chk("tx filter", 8'h01, TX_FILTER);
    cmd(`BCI_LET_REM, "1", 1'b0, 0);
    @(posedge CLK);
    OWN_ADDR_IN_TABLE <= 1'b0;
    cmd(`BCI_LET_TXF, "0", 1'b1, 0);
    chk("tx filter", 8'h01, TX_FILTER);
    @(posedge CLK);
    OWN_ADDR_IN_TABLE <= 1'b1;
    cmd(`BCI_LET_TXF, "0", 1'b1, 0);
    chk("tx filter", 8'h00, TX_FILTER);
    k = nv_n;
    cmd(`BCI_LET_MAINT, "0", 1'b0, 0);
    chk("maint", 8'h00, TABLE_MAINT);
    chk("nv count", k, nv_n);
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    NV_RD_VALID <= 1'b1;
    NV_RD_ADDR <= 4'h1;
    @(posedge CLK);
    NV_RD_ADDR <= 4'h5;
    @(posedge CLK);
    NV_RD_VALID <= 1'b0;
    #1;
    chk("maint", 8'h01, TABLE_MAINT);
    chk("tx filter", 8'h00, TX_FILTER);
    cmd(`BCI_LET_LOAD, "", 1'b0, 0);
    chk("loading", 8'h01, TABLE_LOADING);
    tq.delete();
    cmd(`BCI_LET_TXF, "1", 1'b0, 2);
    chk("table count", 8'h09, tq.size());
    chk("table byte", `BCI_LET_TXF, tq[7]);
    chk("tx filter", 8'h00, TX_FILTER);
    wr(8'h0C, 8'h01);
    chk("loading", 8'h00, TABLE_LOADING);
    cmd(`BCI_LET_TEST, "", 1'b0, 0);
    chk("test tx", 8'h01, TEST_TX);
    wr(8'h0C, 8'h02);
    chk("test tx", 8'h00, TEST_TX);
    cmd(`BCI_LET_TEST, "", 1'b0, 0);
    chk("test tx", 8'h01, TEST_TX);
    cmd(`BCI_LET_BRIDGE, "0", 1'b0, 0);
    chk("test tx", 8'h00, TEST_TX);
    chk("radio", 8'h00, RADIO_EN);
    wr(8'h0C, 8'h04);
    rd(8'h00, 8'hF7, "settings");
    chk("insert count", 8'h02, n_ins);
    chk("table last count", 8'h01, n_tl);
    final_report;
  end

  // A hang is cut short here and counted as a mismatch
  initial
  begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    final_report;
  end
endmodule // bci_cmd_interp_bench

// [bci_consts.vh]
// Constants for the bridge configuration command interpreter
`ifndef BCI_CONSTS_VH
`define BCI_CONSTS_VH
// ============================================================
// Register byte addresses
`define BCI_REG_SETTINGS 8'h00
`define BCI_REG_VALUES   8'h04
`define BCI_REG_STATUS   8'h08
`define BCI_REG_CTRL     8'h0C
// ============================================================
// Control register bits (write only, self clearing)
`define BCI_CTRL_END_LOAD  0
`define BCI_CTRL_STOP_TEST 1
`define BCI_CTRL_DEFAULTS  2
// ============================================================
// Command prefix characters, in order
`define BCI_PREFIX_LEN 3'h7
`define BCI_PFX0 8'h43
`define BCI_PFX1 8'h4F
`define BCI_PFX2 8'h4E
`define BCI_PFX3 8'h46
`define BCI_PFX4 8'h69
`define BCI_PFX5 8'h67
`define BCI_PFX6 8'h46
// ============================================================
// Command selector letters
`define BCI_LET_BRIDGE 8'h65
`define BCI_LET_TXF    8'h74
`define BCI_LET_DLF    8'h64
`define BCI_LET_AGE    8'h61
`define BCI_LET_REM    8'h72
`define BCI_LET_MAINT  8'h73
`define BCI_LET_LOOP   8'h6C
`define BCI_LET_LOAD   8'h77
`define BCI_LET_PRO    8'h70
`define BCI_LET_RESP   8'h6E
`define BCI_LET_TEST   8'h78
// ============================================================
// Space that ends a command and the bounds of the digit range
`define BCI_CH_SPACE 8'h20
`define BCI_CH_ZERO  8'h30
`define BCI_CH_NINE  8'h39
// ============================================================
// Setting indices, also the non-volatile storage address except for maintenance, load, test and none
`define BCI_IDX_BRIDGE 4'h0
`define BCI_IDX_TXF    4'h1
`define BCI_IDX_DLF    4'h2
`define BCI_IDX_AGE    4'h3
`define BCI_IDX_REM    4'h4
`define BCI_IDX_MAINT  4'h5
`define BCI_IDX_LOOP   4'h6
`define BCI_IDX_PRO    4'h7
`define BCI_IDX_RESP   4'h8
`define BCI_IDX_LOAD   4'h9
`define BCI_IDX_TEST   4'hA
`define BCI_IDX_NONE   4'hF
// ============================================================
// Argument limits and defaults
`define BCI_AGE_MAX    7'h3C
`define BCI_PRO_MAX    7'h20
`define BCI_DEF_BRIDGE 1'b1
`define BCI_DEF_TXF    1'b1
`define BCI_DEF_DLF    1'b1
`define BCI_DEF_AGE    6'h05
`define BCI_DEF_REM    1'b0
`define BCI_DEF_MAINT  1'b1
`define BCI_DEF_LOOP   1'b1
`define BCI_DEF_PRO    6'h00
`define BCI_DEF_RESP   1'b1
`endif

// [bci_station.sv]
// Wired station model that sends configuration frames byte by byte
`timescale 1ns/1ps
// ============================================================
// Frame sender
module bci_station (
  input  wire        CLK,
  output logic       RX_VALID,
  output logic [7:0] RX_DATA,
  output logic       RX_LAST,
  output logic       RX_REMOTE
);
  initial
  begin
    RX_VALID = 1'b0;
    RX_DATA = 8'h00;
    RX_LAST = 1'b0;
    RX_REMOTE = 1'b0;
  end
  // Idle data is the inverse of the last byte, so nothing stale looks valid
  task automatic send(input logic [7:0] b [$], input logic rem,
                      input int gap);
    int i;
    for (i = 0; i < b.size(); i++)
    begin
      @(posedge CLK);
      RX_VALID <= 1'b1;
      RX_DATA <= b[i];
      RX_LAST <= (i == b.size() - 1);
      RX_REMOTE <= rem;
      if (gap > 0 || i == b.size() - 1)
      begin
        @(posedge CLK);
        RX_VALID <= 1'b0;
        RX_LAST <= 1'b0;
        RX_DATA <= ~b[i];
        repeat (gap) @(posedge CLK);
      end
    end
  endtask
endmodule // bci_station
